/* File: src/dsp_serial_port.sv */
// Purpose: Slave-only serial port (I2C or SPI) giving a master access to program memory.
// Assumes: All pins are asynchronous and sampled at the system clock.
// Notes:   interface_select high picks I2C, low picks SPI.

`timescale 1ns/1ps
`default_nettype none

module dsp_serial_port
  import dsp_pkg::*;
#(
  parameter int ADDR_W = DSP_ADDR_W
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic interface_select,
  input  wire logic serial_clock,
  input  wire logic data_pin_in,
  output logic      data_pin_out,
  output logic      data_pin_oe,
  input  wire logic chip_select_n_or_gp0,
  output logic      serial_out_or_gp1,
  output logic      serial_out_or_gp1_oe,
  input  wire logic addr_select_hi,
  input  wire logic addr_select_lo
);

  localparam int MEM_DEPTH = 2 ** ADDR_W;

  // ------------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ------------------------------------------------------------------
  logic [5:0] pins_s;
  logic       i2c_mode, scl_s, sda_s, csn_s, ahi_s, alo_s;
  logic       scl_q, sda_q, csn_q;

  dsp_sync #(.WIDTH(6), .INIT(DSP_PIN_RESET)) u_sync (
    .clock (clock),
    .rst   (rst),
    .d     ({interface_select, serial_clock, data_pin_in, chip_select_n_or_gp0,
             addr_select_hi, addr_select_lo}),
    .q     (pins_s)
  );

  assign {i2c_mode, scl_s, sda_s, csn_s, ahi_s, alo_s} = pins_s;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      csn_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      csn_q <= csn_s;
    end
  end

  logic scl_rise, scl_fall, i2c_start, i2c_stop, spi_on;
  assign scl_rise  = scl_s & ~scl_q;
  assign scl_fall  = ~scl_s & scl_q;
  assign i2c_start = scl_s & scl_q & sda_q & ~sda_s;
  assign i2c_stop  = scl_s & scl_q & ~sda_q & sda_s;
  assign spi_on    = ~i2c_mode & ~csn_s;

  // ------------------------------------------------------------------
  // Command tracking and program memory
  // ------------------------------------------------------------------
  logic [7:0] mem [MEM_DEPTH];
  logic [7:0] opcode, mem_addr, rx_byte, rd_byte, tx_pick;
  logic [1:0] byte_idx;
  logic       rx_stb, frame_begin, rd_adv, wr_en, read_active;
  logic       i_rx_stb, i_begin, i_adv, s_rx_stb, s_begin, s_adv;
  logic [7:0] i_shift, s_rx;

  assign rx_stb      = i_rx_stb | s_rx_stb;
  assign frame_begin = i_begin | s_begin;
  assign rd_adv      = i_adv | s_adv;
  assign rx_byte     = i2c_mode ? i_shift : s_rx;
  assign wr_en       = rx_stb && byte_idx == DSP_IDX_PAYLOAD
                       && opcode[7:4] == DSP_OP_WRITE_HI;
  // Every byte from the payload slot on is read data, so later bytes keep streaming.
  assign read_active = opcode == DSP_OP_READ && byte_idx >= DSP_IDX_PAYLOAD;
  assign rd_byte     = mem[mem_addr[ADDR_W-1:0]];
  assign tx_pick     = read_active ? rd_byte : DSP_BYTE_RESET;

  // Opcode, then memory address, then payload; the index saturates after the payload.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      opcode   <= DSP_BYTE_RESET;
      mem_addr <= DSP_BYTE_RESET;
      byte_idx <= DSP_IDX_RESET;
    end else if (frame_begin) begin
      byte_idx <= DSP_IDX_OPCODE;
    end else if (rx_stb) begin
      if (byte_idx == DSP_IDX_OPCODE) begin
        opcode <= rx_byte;
      end
      if (byte_idx == DSP_IDX_MEMADDR) begin
        mem_addr <= rx_byte;
      end
      if (byte_idx != DSP_IDX_LAST) begin
        byte_idx <= byte_idx + 2'h1;
      end
    end else if (rd_adv) begin
      mem_addr <= mem_addr + 8'h01;
    end
  end

  // Memory contents are data, not control state, so they carry no reset.
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[mem_addr[ADDR_W-1:0]] <= rx_byte;
    end
  end

  // ------------------------------------------------------------------
  // I2C engine
  // ------------------------------------------------------------------
  dsp_i2c_state_type i_state;
  logic [2:0]        i_cnt;
  logic [7:0]        i_tx;
  logic              i_flag, i_rw, i_addr_phase;

  // The line is open drain: only a low is ever driven.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      data_pin_out <= 1'b0;
    end else begin
      data_pin_out <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      i_state      <= DSP_I_IDLE;
      i_cnt        <= DSP_BIT_RESET;
      i_shift      <= DSP_BYTE_RESET;
      i_tx         <= DSP_BYTE_RESET;
      i_flag       <= 1'b0;
      i_rw         <= 1'b0;
      i_addr_phase <= 1'b0;
      i_rx_stb     <= 1'b0;
      i_begin      <= 1'b0;
      i_adv        <= 1'b0;
      data_pin_oe  <= 1'b0;
    end else begin
      i_rx_stb <= 1'b0;
      i_begin  <= 1'b0;
      i_adv    <= 1'b0;
      if (!i2c_mode) begin
        i_state     <= DSP_I_IDLE;
        data_pin_oe <= 1'b0;
      end else if (i2c_start) begin
        i_state      <= DSP_I_RECV;
        i_cnt        <= DSP_BIT_RESET;
        i_flag       <= 1'b0;
        i_addr_phase <= 1'b1;
        data_pin_oe  <= 1'b0;
      end else if (i2c_stop) begin
        i_state     <= DSP_I_IDLE;
        data_pin_oe <= 1'b0;
      end else begin
        unique case (i_state)
          DSP_I_IDLE: begin
            data_pin_oe <= 1'b0;
          end
          DSP_I_RECV: begin
            if (scl_rise && !i_flag) begin
              i_shift <= {i_shift[6:0], sda_s};
              i_cnt   <= i_cnt + 3'h1;
              i_flag  <= i_cnt == DSP_BIT_LAST;
            end else if (scl_fall && i_flag) begin
              i_flag <= 1'b0;
              if (i_addr_phase) begin
                if (i_shift[7:1] == {DSP_ADDR_FIXED, ahi_s, alo_s}) begin
                  data_pin_oe  <= 1'b1;
                  i_state      <= DSP_I_ACK;
                  i_rw         <= i_shift[0];
                  i_addr_phase <= 1'b0;
                  i_begin      <= ~i_shift[0];
                end else begin
                  i_state <= DSP_I_IDLE;
                end
              end else begin
                data_pin_oe <= 1'b1;
                i_state     <= DSP_I_ACK;
                i_rx_stb    <= 1'b1;
              end
            end
          end
          DSP_I_ACK: begin
            if (scl_fall) begin
              if (i_rw) begin
                data_pin_oe <= ~tx_pick[7];
                i_tx        <= {tx_pick[6:0], 1'b0};
                i_cnt       <= DSP_BIT_RESET;
                i_adv       <= read_active;
                i_state     <= DSP_I_SEND;
              end else begin
                data_pin_oe <= 1'b0;
                i_state     <= DSP_I_RECV;
              end
            end
          end
          DSP_I_SEND: begin
            if (scl_rise) begin
              i_cnt <= i_cnt + 3'h1;
            end else if (scl_fall) begin
              if (i_cnt == DSP_BIT_RESET) begin
                data_pin_oe <= 1'b0;
                i_flag      <= 1'b0;
                i_state     <= DSP_I_MACK;
              end else begin
                data_pin_oe <= ~i_tx[7];
                i_tx        <= {i_tx[6:0], 1'b0};
              end
            end
          end
          DSP_I_MACK: begin
            if (scl_rise) begin
              if (sda_s) begin
                i_state <= DSP_I_IDLE;
              end else begin
                i_flag <= 1'b1;
              end
            end else if (scl_fall && i_flag) begin
              i_flag      <= 1'b0;
              data_pin_oe <= ~tx_pick[7];
              i_tx        <= {tx_pick[6:0], 1'b0};
              i_cnt       <= DSP_BIT_RESET;
              i_adv       <= read_active;
              i_state     <= DSP_I_SEND;
            end
          end
          default: begin
            i_state <= DSP_I_IDLE;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // SPI engine
  // ------------------------------------------------------------------
  logic       sck_rise, sck_fall;
  logic [2:0] s_cnt;
  logic [7:0] s_tx;

  assign sck_rise = scl_rise;
  assign sck_fall = scl_fall;

  // Leaving select resets the bit count, so a torn frame cannot skew the next one.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_cnt                <= DSP_BIT_RESET;
      s_rx                 <= DSP_BYTE_RESET;
      s_tx                 <= DSP_BYTE_RESET;
      s_rx_stb             <= 1'b0;
      s_begin              <= 1'b0;
      s_adv                <= 1'b0;
      serial_out_or_gp1    <= 1'b0;
      serial_out_or_gp1_oe <= 1'b0;
    end else begin
      s_rx_stb <= 1'b0;
      s_begin  <= 1'b0;
      s_adv    <= 1'b0;
      if (!spi_on) begin
        s_cnt                <= DSP_BIT_RESET;
        serial_out_or_gp1    <= 1'b0;
        serial_out_or_gp1_oe <= 1'b0;
      end else begin
        serial_out_or_gp1_oe <= 1'b1;
        s_begin              <= csn_q;
        if (sck_rise) begin
          if (s_cnt == DSP_BIT_RESET) begin
            serial_out_or_gp1 <= tx_pick[7];
            s_tx              <= {tx_pick[6:0], 1'b0};
            s_adv             <= read_active;
          end else begin
            serial_out_or_gp1 <= s_tx[7];
            s_tx              <= {s_tx[6:0], 1'b0};
          end
        end
        if (sck_fall) begin
          s_rx     <= {s_rx[6:0], sda_s};
          s_cnt    <= s_cnt + 3'h1;
          s_rx_stb <= s_cnt == DSP_BIT_LAST;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  i2c_quiet_a: assert property (!i2c_mode |=> !data_pin_oe)
    else $error("I2C data line driven in SPI mode");
  spi_quiet_a: assert property (i2c_mode |=> !serial_out_or_gp1_oe)
    else $error("SPI output enabled in I2C mode");
  spi_select_a: assert property (csn_s |=> !serial_out_or_gp1_oe && s_cnt == 3'h0)
    else $error("SPI active while select is high");
  start_seen_a: assert property (i2c_mode && i2c_start |=> i_state == DSP_I_RECV && i_cnt == 3'h0)
    else $error("Start condition not taken");
  rise_sample_a: assert property (i2c_mode && !i2c_start && !i2c_stop && i_state == DSP_I_RECV
      && scl_rise && !i_flag |=> i_shift[0] == $past(sda_s))
    else $error("I2C bit not sampled at rising clock");
  addr_match_a: assert property (i_begin |-> $past(i_shift[7:1]) ==
      {DSP_ADDR_FIXED, $past(ahi_s), $past(alo_s)})
    else $error("Frame began on foreign address");
  ack_drive_a: assert property (i_rx_stb |-> data_pin_oe && i_state == DSP_I_ACK)
    else $error("Received byte not acknowledged");
  sram_write_a: assert property (wr_en |=> mem[$past(mem_addr[ADDR_W-1:0])] == $past(rx_byte))
    else $error("Program memory write lost");
  read_load_a: assert property (i2c_mode && !i2c_start && !i2c_stop && i_state == DSP_I_ACK
      && scl_fall && i_rw && read_active |=> data_pin_oe == !$past(rd_byte[7]) && i_adv)
    else $error("Read payload not presented");
  nack_end_a: assert property (i2c_mode && !i2c_start && !i2c_stop && i_state == DSP_I_MACK
      && scl_rise && sda_s |=> i_state == DSP_I_IDLE)
    else $error("Not-acknowledge did not end the read");
  spi_byte_a: assert property (s_rx_stb |-> s_cnt == 3'h0 && s_rx[0] == $past(sda_s))
    else $error("SPI byte boundary wrong");
  spi_shift_a: assert property (spi_on && sck_rise && s_cnt != 3'h0
      |=> serial_out_or_gp1 == $past(s_tx[7]))
    else $error("SPI output not shifted on rising edge");

  i2c_write_c: cover property (wr_en && i2c_mode);
  spi_write_c: cover property (wr_en && !i2c_mode);
  i2c_read_c:  cover property (i_adv ##[1:1000] i_state == DSP_I_MACK);

endmodule

`default_nettype wire

/* File: inc/dsp_pkg.sv */
// Purpose: Shared constants and types for the dual serial slave port.
// Assumes: Byte-wide program memory reached through an 8-bit memory address.
// Notes:   Only the opcodes that touch the volatile program memory are decoded.

package dsp_pkg;

  // ------------------------------------------------------------------
  // Addressing and opcodes
  // ------------------------------------------------------------------
  localparam logic [4:0] DSP_ADDR_FIXED    = 5'h14;
  localparam logic [3:0] DSP_OP_WRITE_HI   = 4'h9;
  localparam logic [7:0] DSP_OP_READ       = 8'h10;
  localparam int         DSP_ADDR_W        = 8;
  localparam int         DSP_I2C_MAX_KHZ   = 100;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [5:0] DSP_PIN_RESET     = 6'h3c;
  localparam logic [7:0] DSP_BYTE_RESET    = 8'h00;
  localparam logic [2:0] DSP_BIT_RESET     = 3'h0;
  localparam logic [1:0] DSP_IDX_RESET     = 2'h0;

  // ------------------------------------------------------------------
  // Frame positions
  // ------------------------------------------------------------------
  localparam logic [1:0] DSP_IDX_OPCODE    = 2'h0;
  localparam logic [1:0] DSP_IDX_MEMADDR   = 2'h1;
  localparam logic [1:0] DSP_IDX_PAYLOAD   = 2'h2;
  localparam logic [1:0] DSP_IDX_LAST      = 2'h3;
  localparam logic [2:0] DSP_BIT_LAST      = 3'h7;

  typedef enum logic [2:0] {
    DSP_I_IDLE = 3'b000,
    DSP_I_RECV = 3'b001,
    DSP_I_ACK  = 3'b010,
    DSP_I_SEND = 3'b011,
    DSP_I_MACK = 3'b100
  } dsp_i2c_state_type;

endpackage

/* File: src/dsp_sync.sv */
// Purpose: Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes: Each bit is an independent level; no bus coherency is implied.
// Notes:   The first stage is read by the second stage only.

`timescale 1ns/1ps
`default_nettype none

module dsp_sync #(
  parameter int                 WIDTH = 6,
  parameter logic [WIDTH-1:0]   INIT  = '0
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage1 <= INIT;
      q      <= INIT;
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end

endmodule

`default_nettype wire

/* File: dv/dsp_master_model.sv */
// Purpose: Behavioural bus master that works the port pins as an I2C or SPI master.
// Assumes: Pins change only at falling system clock edges; half a link period is 8 clocks.
// Notes:   Runs well above the recommended I2C rate to keep the run short.

`timescale 1ns/1ps
`default_nettype none

module dsp_master_model (
  input  wire logic       clock,
  input  wire logic       data_pin_oe,
  input  wire logic       data_pin_out,
  input  wire logic       serial_out_or_gp1,
  input  wire logic       serial_out_or_gp1_oe,
  output logic            scl,
  output logic            data_line,
  output logic            cs_n,
  output logic            obs_valid,
  output logic      [7:0] obs_value
);
  // Far above the recommended I2C ceiling; the port is sampled fast enough to follow.
  localparam int HALF = 8;
  logic sda_m;
  logic miso_last;
  logic miso_line;

  // The data line has a pull-up, so it reads high once both parties let go.
  assign data_line = sda_m & ~(data_pin_oe & ~data_pin_out);
  // A released output line shows the inverse of its last level, never a stale copy.
  assign miso_line = serial_out_or_gp1_oe ? serial_out_or_gp1 : ~miso_last;

  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
    cs_n = 1'b1;
    obs_valid = 1'b0;
    obs_value = 8'h00;
    miso_last = 1'b0;
  end

  always @(posedge clock) begin
    if (serial_out_or_gp1_oe) begin
      miso_last <= serial_out_or_gp1;
    end
  end

  task automatic hold(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic report(input logic [7:0] v);
    obs_value = v;
    obs_valid = 1'b1;
    hold(1);
    obs_valid = 1'b0;
  endtask

  task automatic i2c_start();
    scl = 1'b0;
    hold(2);
    sda_m = 1'b1;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    sda_m = 1'b0;
    hold(HALF);
  endtask

  task automatic i2c_stop();
    scl = 1'b0;
    hold(2);
    sda_m = 1'b0;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    sda_m = 1'b1;
    hold(HALF);
  endtask

  // Eight data bits MSB first, then the acknowledge slot; the line only moves while clock is low.
  task automatic i2c_xfer(input logic [7:0] tx, input logic last, input logic rep_rx);
    logic [8:0] bits;
    logic [8:0] rx;
    bits = {tx, last};
    for (int i = 8; i >= 0; i--) begin
      scl = 1'b0;
      hold(2);
      sda_m = bits[i];
      hold(HALF);
      scl = 1'b1;
      hold(HALF);
      rx[i] = data_line;
    end
    report(rep_rx ? rx[8:1] : {7'h00, rx[0]});
  endtask

  task automatic spi_select(input logic sel);
    // The SPI clock must idle low, or the first rising edge of a frame is lost.
    scl = 1'b0;
    hold(HALF);
    cs_n = ~sel;
    hold(HALF);
  endtask

  task automatic spi_byte(input logic [7:0] tx, input logic rep_rx);
    logic [7:0] rx;
    for (int i = 7; i >= 0; i--) begin
      scl = 1'b1;
      sda_m = tx[i];
      hold(HALF);
      scl = 1'b0;
      rx[i] = miso_line;
      hold(HALF);
    end
    if (rep_rx) begin
      report(rx);
    end
  endtask
endmodule

`default_nettype wire

/* File: dv/dual_serial_slave_port_bench.sv */
// Purpose: Self-checking bench for the dual serial slave port.
// Assumes: One shared program memory behind both ports.
// Notes:   Expected acknowledges and read bytes queue up in the order the master meets them.

`timescale 1ns/1ps
`default_nettype none

module dual_serial_slave_port_bench;
  localparam int LIMIT = 40000;
  logic       clock;
  logic       rst;
  logic       interface_select;
  logic       addr_select_hi;
  logic       addr_select_lo;
  logic       scl;
  logic       data_line;
  logic       cs_n;
  logic       obs_valid;
  logic [7:0] obs_value;
  logic       data_pin_out;
  logic       data_pin_oe;
  logic       serial_out_or_gp1;
  logic       serial_out_or_gp1_oe;
  logic [7:0] rnd;
  logic [7:0] base;
  logic [7:0] mem [256];
  logic [7:0] expq [$];
  int         error_cnt = 0;
  int         tests_run = 0;
  int         cyc = 0;

  dsp_serial_port dsp_serial_port_inst (
    .clock                (clock),
    .rst                  (rst),
    .interface_select     (interface_select),
    .serial_clock         (scl),
    .data_pin_in          (data_line),
    .data_pin_out         (data_pin_out),
    .data_pin_oe          (data_pin_oe),
    .chip_select_n_or_gp0 (cs_n),
    .serial_out_or_gp1    (serial_out_or_gp1),
    .serial_out_or_gp1_oe (serial_out_or_gp1_oe),
    .addr_select_hi       (addr_select_hi),
    .addr_select_lo       (addr_select_lo)
  );

  dsp_master_model dsp_master_model_inst (
    .clock                (clock),
    .data_pin_oe          (data_pin_oe),
    .data_pin_out         (data_pin_out),
    .serial_out_or_gp1    (serial_out_or_gp1),
    .serial_out_or_gp1_oe (serial_out_or_gp1_oe),
    .scl                  (scl),
    .data_line            (data_line),
    .cs_n                 (cs_n),
    .obs_valid            (obs_valid),
    .obs_value            (obs_value)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic i2c_w(input logic [6:0] a, input logic [7:0] op, input logic [7:0] m,
                       input logic [7:0] d, input logic ok);
    for (int i = 0; i < 4; i++) begin
      expq.push_back({7'h00, ~ok});
    end
    if (ok) begin
      mem[m] = d;
    end
    dsp_master_model_inst.i2c_start();
    dsp_master_model_inst.i2c_xfer({a, 1'b0}, 1'b1, 1'b0);
    dsp_master_model_inst.i2c_xfer(op, 1'b1, 1'b0);
    dsp_master_model_inst.i2c_xfer(m, 1'b1, 1'b0);
    dsp_master_model_inst.i2c_xfer(d, 1'b1, 1'b0);
    dsp_master_model_inst.i2c_stop();
  endtask

  task automatic i2c_r(input logic [6:0] a, input logic [7:0] m);
    for (int i = 0; i < 4; i++) begin
      expq.push_back(8'h00);
    end
    expq.push_back(mem[m]);
    expq.push_back(mem[m + 8'h01]);
    dsp_master_model_inst.i2c_start();
    dsp_master_model_inst.i2c_xfer({a, 1'b0}, 1'b1, 1'b0);
    dsp_master_model_inst.i2c_xfer(8'h10, 1'b1, 1'b0);
    dsp_master_model_inst.i2c_xfer(m, 1'b1, 1'b0);
    dsp_master_model_inst.i2c_start();
    dsp_master_model_inst.i2c_xfer({a, 1'b1}, 1'b1, 1'b0);
    dsp_master_model_inst.i2c_xfer(8'hff, 1'b0, 1'b1);
    dsp_master_model_inst.i2c_xfer(8'hff, 1'b1, 1'b1);
    dsp_master_model_inst.i2c_stop();
  endtask

  task automatic spi_w(input logic [7:0] op, input logic [7:0] m, input logic [7:0] d);
    mem[m] = d;
    dsp_master_model_inst.spi_select(1'b1);
    dsp_master_model_inst.spi_byte(op, 1'b0);
    dsp_master_model_inst.spi_byte(m, 1'b0);
    dsp_master_model_inst.spi_byte(d, 1'b0);
    dsp_master_model_inst.spi_select(1'b0);
  endtask

  task automatic spi_r(input logic [7:0] m);
    expq.push_back(mem[m]);
    expq.push_back(mem[m + 8'h01]);
    dsp_master_model_inst.spi_select(1'b1);
    dsp_master_model_inst.spi_byte(8'h10, 1'b0);
    dsp_master_model_inst.spi_byte(m, 1'b0);
    dsp_master_model_inst.spi_byte(8'hff, 1'b1);
    dsp_master_model_inst.spi_byte(8'hff, 1'b1);
    dsp_master_model_inst.spi_select(1'b0);
  endtask

  // Results are compared in the order the master produced them.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (obs_valid) begin
      check("serial result", obs_value, expq.pop_front());
    end
    if (cyc == LIMIT) begin
      error_cnt++;
      summarize();
    end
  end

  initial begin
    rst = 1'b1;
    interface_select = 1'b1;
    addr_select_hi = 1'b0;
    addr_select_lo = 1'b0;
    rnd = 8'h3a;
    repeat (2) @(negedge clock);
    check("reset data oe", {7'h00, data_pin_oe}, 8'h00);
    check("reset serial oe", {7'h00, serial_out_or_gp1_oe}, 8'h00);
    rst = 1'b0;
    repeat (6) @(negedge clock);
    rnd = lfsr(rnd);
    base = rnd;
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      i2c_w(7'h50, {4'h9, rnd[3:0]}, base + 8'(k), rnd, 1'b1);
    end
    i2c_r(7'h50, base);
    i2c_r(7'h50, base + 8'h02);
    // Every address-select setting: the own address answers, the one with both select bits inverted does not.
    for (int s = 0; s < 4; s++) begin
      addr_select_hi = s[1];
      addr_select_lo = s[0];
      repeat (6) @(negedge clock);
      rnd = lfsr(rnd);
      i2c_w(7'h50 | 7'(s), 8'h90, base + 8'(s), rnd, 1'b1);
      i2c_w(7'h50 | 7'(s ^ 3), 8'h90, base + 8'h10, rnd, 1'b0);
    end
    i2c_r(7'h53, base);
    {addr_select_hi, addr_select_lo} = 2'b00;
    interface_select = 1'b0;
    repeat (6) @(negedge clock);
    i2c_w(7'h50, 8'h90, base, ~mem[base], 1'b0);
    spi_r(base);
    for (int k = 8; k < 12; k++) begin
      rnd = lfsr(rnd);
      spi_w({4'h9, rnd[7:4]}, base + 8'(k), rnd);
    end
    spi_r(base + 8'h08);
    spi_r(base + 8'h0a);
    interface_select = 1'b1;
    repeat (6) @(negedge clock);
    dsp_master_model_inst.spi_select(1'b1);
    dsp_master_model_inst.spi_byte(8'h10, 1'b0);
    check("spi oe in i2c mode", {7'h00, serial_out_or_gp1_oe}, 8'h00);
    dsp_master_model_inst.spi_select(1'b0);
    i2c_r(7'h50, base + 8'h08);
    repeat (4) @(negedge clock);
    check("pending results", 8'(expq.size()), 8'h00);
    summarize();
  end
endmodule

`default_nettype wire
